// >>> shared/sdmi_pkg.sv
// package for the sdram mode-register programming block
// How it works
// - register writes and dll reset never touch array contents
// - main register write: cs, ras, cas, we, both bank bits low
// - main register fields: burst length, order, latency, dll reset, recovery
// - ext reg one write: bank bit1 low, bank bit0 high, rest low
// - ext reg one fields: dll off, drive, termination, latency, calibration, strobes
// - dll switches off in self refresh, back on when leaving it
// - read-only strobe enabled disables write data mask; x16 forces it zero
// - ext reg two write: bank bit0 low, bank bit1 high
package sdmi_pkg;
  localparam int ADDR_W = 14;
  // main register field positions
  localparam int MAIN_BL_LSB   = 0;
  localparam int MAIN_BT_BIT   = 3;
  localparam int MAIN_CL_LSB   = 4;
  localparam int MAIN_DLLR_BIT = 8;
  localparam int MAIN_WR_LSB   = 9;
  // ext register one field positions
  localparam int E1_DLLDIS_BIT = 0;
  localparam int E1_DRV_BIT    = 1;
  localparam int E1_RTT0_BIT   = 2;
  localparam int E1_ADDLAT_LSB   = 3;
  localparam int E1_RTT1_BIT     = 6;
  localparam int E1_CALIB_LSB    = 7;
  localparam int E1_NDQS_BIT     = 10;
  localparam int E1_RDSTROBE_BIT = 11;
  // ext register two field positions
  localparam int E2_PASR_LSB = 0;
  localparam int E2_SRFT_BIT = 7;
  // calibration codes
  localparam logic [2:0] CALIB_EXIT    = 3'h0;
  localparam logic [2:0] CALIB_DEFAULT = 3'h7;
  // reset values of stored fields
  localparam logic [ADDR_W-1:0] REG_RST = 14'h0000;
  // dll lock wait
  localparam int DLL_LOCK_CYC = 200;
  localparam logic [7:0] DLL_LOCK_W = 8'hc8;
  typedef enum logic [2:0] {
    SDMI_CMD_NOP = 3'h0, SDMI_CMD_REGSET = 3'h1, SDMI_CMD_REF = 3'h2,
    SDMI_CMD_SRE = 3'h3, SDMI_CMD_SRX = 3'h4, SDMI_CMD_RD = 3'h5,
    SDMI_CMD_OTHER = 3'h6
  } sdmi_cmd_type;
endpackage : sdmi_pkg

// >>> shared/sdmi_cmd_if.sv
// interface carrying a decoded command from decoder to register file
`timescale 1ns/100ps
interface sdmi_cmd_if;
  import sdmi_pkg::*;
  sdmi_cmd_type      cmd;
  logic [1:0]        bank;
  logic [ADDR_W-1:0] addr;
  modport dec (output cmd, output bank, output addr);
  modport sink (input cmd, input bank, input addr);
endinterface : sdmi_cmd_if

// >>> rtl/sdmi_cmd_decode.sv
// command decoder from synchronised pin levels
`timescale 1ns/100ps
module sdmi_cmd_decode
  import sdmi_pkg::*;
(
  // pins
  input  wire logic              cke_prev_i,
  input  wire logic              cke_i,
  input  wire logic              cs_n_i,
  input  wire logic              ras_n_i,
  input  wire logic              cas_n_i,
  input  wire logic              we_n_i,
  input  wire logic [1:0]        bank_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  // decoded
  sdmi_cmd_if.dec                 out
);
  // truth table decode; register set needs all four strobes low
  always_comb begin
    out.bank = bank_i;
    out.addr = addr_i;
    out.cmd  = SDMI_CMD_NOP;
    if (cke_prev_i && cke_i && !cs_n_i) begin
      case ({ras_n_i, cas_n_i, we_n_i})
        3'h0:    out.cmd = SDMI_CMD_REGSET;
        3'h1:    out.cmd = SDMI_CMD_REF;
        3'h5:    out.cmd = SDMI_CMD_RD;
        3'h7:    out.cmd = SDMI_CMD_NOP;
        default: out.cmd = SDMI_CMD_OTHER;
      endcase
    end else if (cke_prev_i && !cke_i && !cs_n_i && !ras_n_i && !cas_n_i && we_n_i) begin
      out.cmd = SDMI_CMD_SRE;
    end else if (!cke_prev_i && cke_i) begin
      out.cmd = SDMI_CMD_SRX;
    end
  end
endmodule : sdmi_cmd_decode

// >>> rtl/sdmi_mode_regs.sv
// mode and extended mode registers of the sdram, with dll state
`timescale 1ns/100ps
module sdmi_mode_regs
  import sdmi_pkg::*;
#(
  parameter bit X16 = 1'b0
) (
  // clock and reset
  input  wire logic              clk_i,
  input  wire logic              rstn_i,
  // memory pins
  input  wire logic              cke_i,
  input  wire logic              cs_n_i,
  input  wire logic              ras_n_i,
  input  wire logic              cas_n_i,
  input  wire logic              we_n_i,
  input  wire logic              bank_sel_bit0_i,
  input  wire logic              bank_sel_bit1_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  // main register fields
  output logic [2:0]             burst_len_o,
  output logic                   burst_order_o,
  output logic [2:0]             read_latency_o,
  output logic [2:0]             write_recovery_o,
  // ext register one fields
  output logic                   dll_disable_o,
  output logic                   reduced_drive_o,
  output logic [1:0]             term_value_o,
  output logic [2:0]             added_latency_o,
  output logic [2:0]             calib_ctrl_o,
  output logic                   strobe_n_disable_o,
  output logic                   read_only_strobe_o,
  output logic                   write_data_mask_en_o,
  // ext register two fields
  output logic [2:0]             partial_refresh_o,
  output logic                   hot_self_refresh_o,
  // dll, self refresh and write pulse status
  output logic                   dll_on_o,
  output logic                   dll_locked_o,
  output logic                   self_refresh_o,
  output logic                   reg_written_o
);
  logic [ADDR_W+7:0] pin_s0_reg, pin_s1_reg;
  logic              cke_prev_reg;
  logic [ADDR_W-1:0] main_reg, ext1_reg, ext2_reg, ext3_reg;
  logic              sref_reg;
  logic [7:0]        lock_cnt_reg;
  logic              wr_pulse_reg;
  sdmi_cmd_if        cmd ();

  // two-stage synchroniser for all pins
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      pin_s0_reg <= '0;
      pin_s1_reg <= '0;
    end else begin
      pin_s0_reg <= {cke_i, cs_n_i, ras_n_i, cas_n_i, we_n_i,
                     bank_sel_bit1_i, bank_sel_bit0_i, 1'b0, addr_i};
      pin_s1_reg <= pin_s0_reg;
    end
  end
  // previous clock-enable level for entry and exit decode
  always_ff @(posedge clk_i) begin
    if (!rstn_i) cke_prev_reg <= 1'b0;
    else         cke_prev_reg <= pin_s1_reg[ADDR_W+7];
  end

  sdmi_cmd_decode u_dec (
    .cke_prev_i (cke_prev_reg),
    .cke_i      (pin_s1_reg[ADDR_W+7]),
    .cs_n_i     (pin_s1_reg[ADDR_W+6]),
    .ras_n_i    (pin_s1_reg[ADDR_W+5]),
    .cas_n_i    (pin_s1_reg[ADDR_W+4]),
    .we_n_i     (pin_s1_reg[ADDR_W+3]),
    .bank_i     (pin_s1_reg[ADDR_W+2:ADDR_W+1]),
    .addr_i     (pin_s1_reg[ADDR_W-1:0]),
    .out        (cmd.dec)
  );

  // register set: the bank bits select which register takes the whole word
  // array contents are not reachable from here, so writes never disturb them
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      main_reg <= REG_RST;
      ext1_reg <= REG_RST;
      ext2_reg <= REG_RST;
      ext3_reg <= REG_RST;
    end else if (cmd.cmd == SDMI_CMD_REGSET) begin
      case (cmd.bank)
        2'h0:    main_reg <= cmd.addr;
        2'h1:    ext1_reg <= cmd.addr;
        2'h2:    ext2_reg <= cmd.addr;
        default: ext3_reg <= cmd.addr;
      endcase
    end
  end

  // write pulse for observation, rises on the same edge as the stored word
  always_ff @(posedge clk_i) begin
    if (!rstn_i) wr_pulse_reg <= 1'b0;
    else         wr_pulse_reg <= (cmd.cmd == SDMI_CMD_REGSET);
  end

  // self refresh tracking turns the dll off and back on
  always_ff @(posedge clk_i) begin
    if (!rstn_i)                        sref_reg <= 1'b0;
    else if (cmd.cmd == SDMI_CMD_SRE)   sref_reg <= 1'b1;
    else if (cmd.cmd == SDMI_CMD_SRX)   sref_reg <= 1'b0;
  end

  // dll lock counter restarts on a dll reset write or self refresh exit
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      lock_cnt_reg <= 8'h00;
    end else if (!dll_on_o) begin
      lock_cnt_reg <= 8'h00;
    end else if ((cmd.cmd == SDMI_CMD_REGSET && cmd.bank == 2'h0 && cmd.addr[MAIN_DLLR_BIT])
                 || cmd.cmd == SDMI_CMD_SRX) begin
      lock_cnt_reg <= 8'h00;
    end else if (lock_cnt_reg != DLL_LOCK_W) begin
      lock_cnt_reg <= lock_cnt_reg + 8'h01;
    end
  end

  // field outputs from the stored words
  assign burst_len_o        = main_reg[MAIN_BL_LSB +: 3];
  assign burst_order_o      = main_reg[MAIN_BT_BIT];
  assign read_latency_o     = main_reg[MAIN_CL_LSB +: 3];
  assign write_recovery_o   = main_reg[MAIN_WR_LSB +: 3];
  assign dll_disable_o      = ext1_reg[E1_DLLDIS_BIT];
  assign reduced_drive_o    = ext1_reg[E1_DRV_BIT];
  assign term_value_o       = {ext1_reg[E1_RTT1_BIT], ext1_reg[E1_RTT0_BIT]};
  assign added_latency_o    = ext1_reg[E1_ADDLAT_LSB +: 3];
  assign calib_ctrl_o       = ext1_reg[E1_CALIB_LSB +: 3];
  assign strobe_n_disable_o = ext1_reg[E1_NDQS_BIT];
  assign read_only_strobe_o = ext1_reg[E1_RDSTROBE_BIT] && !X16;
  assign write_data_mask_en_o = !read_only_strobe_o;
  assign partial_refresh_o  = ext2_reg[E2_PASR_LSB +: 3];
  assign hot_self_refresh_o = ext2_reg[E2_SRFT_BIT];
  assign dll_on_o           = !ext1_reg[E1_DLLDIS_BIT] && !sref_reg;
  assign dll_locked_o       = dll_on_o && (lock_cnt_reg == DLL_LOCK_W);
  assign self_refresh_o     = sref_reg;
  assign reg_written_o      = wr_pulse_reg;
endmodule : sdmi_mode_regs

// >>> sim/sdmi_ctrl_model.sv
// controller model that drives the memory command pins
`timescale 1ns/100ps
module sdmi_ctrl_model
  import sdmi_pkg::*;
(
  // clock
  input  wire logic        clk_i,
  // command pins, cmd_o is {ras, cas, we}
  output logic             cke_o,
  output logic             cs_n_o,
  output logic [2:0]       cmd_o,
  output logic [1:0]       bank_o,
  output logic [ADDR_W-1:0] addr_o
);
  logic k;
  logic termination_enable;
  // clock-enable and termination low while power ramps
  initial begin
    k = 1'b0;
    termination_enable = 1'b0;
    {cke_o, cs_n_o, cmd_o, bank_o, addr_o} = {1'b0, 1'b1, 3'h7, 2'h0, 14'h0};
  end
  // deselect cycles, cke held at k, address toggles and command and bank lines take random values each cycle
  task automatic idle(input int n);
    repeat (n) begin
      @(posedge clk_i);
      #1;
      {cke_o, cs_n_o, cmd_o, bank_o} = {k, 1'b1, 5'($urandom)};
      addr_o = ~addr_o;
    end
  endtask : idle
  // one command cycle, then spacing for the set cycle time
  task automatic cmd(input logic [2:0] c, input logic [1:0] b, input logic [ADDR_W-1:0] a);
    @(posedge clk_i);
    #1;
    {cke_o, cs_n_o, cmd_o, bank_o, addr_o} = {k, 1'b0, c, b, a};
    idle(4);
  endtask : cmd
endmodule : sdmi_ctrl_model

// >>> sim/sdmi_props.sv
// checker for the mode-register block
`timescale 1ns/100ps
module sdmi_props
  import sdmi_pkg::*;
(
  input wire logic clk_i, rstn_i, cke_i, cs_n_i, ras_n_i, cas_n_i, we_n_i,
  input wire logic bank_sel_bit0_i, bank_sel_bit1_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [2:0] burst_len_o, read_latency_o, write_recovery_o,
  input wire logic [2:0] added_latency_o, calib_ctrl_o, partial_refresh_o,
  input wire logic [1:0] term_value_o,
  input wire logic burst_order_o, dll_disable_o, reduced_drive_o, strobe_n_disable_o,
  input wire logic read_only_strobe_o, write_data_mask_en_o, hot_self_refresh_o,
  input wire logic dll_on_o, dll_locked_o, self_refresh_o, reg_written_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  logic cke_q_reg;
  // previous clock-enable level
  always_ff @(posedge clk_i) cke_q_reg <= cke_i;
  wire [1:0] bank = {bank_sel_bit1_i, bank_sel_bit0_i};
  wire set_cmd = cke_q_reg & cke_i & ~cs_n_i & ~ras_n_i & ~cas_n_i & ~we_n_i;
  wire sr_cmd = cke_q_reg & ~cke_i & ~cs_n_i & ~ras_n_i & ~cas_n_i & we_n_i;
  main_fields_a: assert property (set_cmd && bank == 2'h0 |-> ##3
    {write_recovery_o, read_latency_o, burst_order_o, burst_len_o}
    == $past({addr_i[11:9], addr_i[6:0]}, 3)) else $error("main fields wrong");
  ext1_fields_a: assert property (set_cmd && bank == 2'h1 |-> ##3
    {strobe_n_disable_o, calib_ctrl_o, added_latency_o, reduced_drive_o, dll_disable_o}
    == $past({addr_i[10:7], addr_i[5:3], addr_i[1:0]}, 3)) else $error("ext1 fields wrong");
  term_field_a: assert property (set_cmd && bank == 2'h1 |-> ##3
    term_value_o == $past({addr_i[6], addr_i[2]}, 3)) else $error("termination field wrong");
  ext2_fields_a: assert property (set_cmd && bank == 2'h2 |-> ##3
    {hot_self_refresh_o, partial_refresh_o} == $past({addr_i[7], addr_i[2:0]}, 3))
    else $error("ext2 fields wrong");
  write_pulse_a: assert property (set_cmd |-> ##3 reg_written_o)
    else $error("no write pulse");
  stray_pulse_a: assert property (!$past(set_cmd, 3) |-> !reg_written_o)
    else $error("pulse without write");
  mask_strobe_a: assert property (read_only_strobe_o |-> !write_data_mask_en_o)
    else $error("mask active with read strobe");
  dll_lock_a: assert property (set_cmd && bank == 2'h0 && addr_i[8] |-> ##3
    !dll_locked_o ##190 !dll_locked_o ##[1:20] dll_locked_o) else $error("lock timing wrong");
  sr_entry_a: assert property (sr_cmd |-> ##[1:5] self_refresh_o)
    else $error("self refresh not entered");
  dll_off_sr_a: assert property (self_refresh_o |-> !dll_on_o)
    else $error("dll on in self refresh");
  cover property (set_cmd && bank == 2'h0 && addr_i[8]);
  cover property (sr_cmd);
  cover property (read_only_strobe_o);
endmodule : sdmi_props
bind sdmi_mode_regs sdmi_props u_props (.clk_i, .rstn_i, .cke_i, .cs_n_i, .ras_n_i,
  .cas_n_i, .we_n_i, .bank_sel_bit0_i, .bank_sel_bit1_i, .addr_i, .burst_len_o,
  .read_latency_o, .write_recovery_o, .added_latency_o, .calib_ctrl_o,
  .partial_refresh_o, .term_value_o, .burst_order_o, .dll_disable_o, .reduced_drive_o,
  .strobe_n_disable_o, .read_only_strobe_o, .write_data_mask_en_o,
  .hot_self_refresh_o, .dll_on_o, .dll_locked_o, .self_refresh_o, .reg_written_o);

// >>> sim/test_sdram_init_mode_program.sv
// self-checking bench for the mode-register block
`timescale 1ns/100ps
module test_sdram_init_mode_program;
  import sdmi_pkg::*;
  localparam int PWRUP_CYC = 500; // power-up wait, shortened
  logic clk_i, rstn_i, burst_order_o, dll_disable_o, reduced_drive_o, strobe_n_disable_o;
  logic read_only_strobe_o, write_data_mask_en_o, hot_self_refresh_o, dll_on_o;
  logic dll_locked_o, self_refresh_o, reg_written_o;
  logic [2:0] burst_len_o, read_latency_o, write_recovery_o, added_latency_o;
  logic [2:0] calib_ctrl_o, partial_refresh_o;
  logic [1:0] term_value_o;
  wire cke_i, cs_n_i;
  wire [2:0] cmdv;
  wire [1:0] bank;
  wire [ADDR_W-1:0] addr_i;
  logic [ADDR_W-1:0] m0, e1, e2;
  logic [ADDR_W-1:0] mk [4] = '{14'h0e7f, 14'h0fff, 14'h0087, 14'h0000};
  logic [26:0] q [$];
  int n_errors, comparisons, cycles;
  wire [26:0] obs = {write_recovery_o, read_latency_o, burst_order_o, burst_len_o,
    strobe_n_disable_o, calib_ctrl_o, added_latency_o, term_value_o, reduced_drive_o,
    dll_disable_o, read_only_strobe_o, write_data_mask_en_o, hot_self_refresh_o,
    partial_refresh_o};
  sdmi_ctrl_model u_c (.clk_i, .cke_o(cke_i), .cs_n_o(cs_n_i), .cmd_o(cmdv),
    .bank_o(bank), .addr_o(addr_i));
  sdmi_mode_regs u_sdmi_mode_regs (.clk_i, .rstn_i, .cke_i, .cs_n_i, .ras_n_i(cmdv[2]),
    .cas_n_i(cmdv[1]), .we_n_i(cmdv[0]), .bank_sel_bit0_i(bank[0]),
    .bank_sel_bit1_i(bank[1]), .addr_i, .burst_len_o, .burst_order_o, .read_latency_o,
    .write_recovery_o, .dll_disable_o, .reduced_drive_o, .term_value_o, .added_latency_o,
    .calib_ctrl_o, .strobe_n_disable_o, .read_only_strobe_o, .write_data_mask_en_o,
    .partial_refresh_o, .hot_self_refresh_o, .dll_on_o, .dll_locked_o, .self_refresh_o,
    .reg_written_o);
  task automatic chk(input logic [26:0] got, input logic [26:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic complete_run();
    if (n_errors == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : complete_run
  // register write: update shadow, note expected fields, issue the command
  task automatic wr(input logic [1:0] b, input logic [ADDR_W-1:0] a);
    if (b == 2'h0) m0 = a;
    if (b == 2'h1) e1 = a;
    if (b == 2'h2) e2 = a;
    q.push_back({m0[11:9], m0[6:0], e1[10:7], e1[5:3], e1[6], e1[2], e1[1:0], e1[11],
      ~e1[11], e2[7], e2[2:0]});
    u_c.cmd(3'h0, b, a);
  endtask : wr
  // clock and timeout
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      complete_run();
    end
  end
  // watcher: each write pulse takes the oldest note, looked at mid-cycle
  always @(negedge clk_i)
    if (rstn_i === 1'b1 && reg_written_o !== 1'b0)
      chk(obs, (q.size() > 0) ? q.pop_front() : ~obs);
  // main sequence
  initial begin
    {rstn_i, m0, e1, e2, n_errors, comparisons, cycles} = '0;
    void'($urandom(32'h2ee26700));
    repeat (10) @(posedge clk_i);
    #1 rstn_i = 1'b1;
    @(posedge clk_i);
    chk(obs, 27'h10); // reset values
    u_c.idle(PWRUP_CYC);
    u_c.k = 1'b1;
    u_c.idle(100);
    u_c.cmd(3'h2, 2'h0, 14'h0400);
    wr(2'h2, 14'($urandom) & mk[2]);
    wr(2'h3, 14'h0000);
    wr(2'h1, 14'($urandom) & 14'h0c7e);
    wr(2'h0, (14'($urandom) & mk[0]) | 14'h0100);
    u_c.cmd(3'h2, 2'h0, 14'h0400);
    repeat (2) u_c.cmd(3'h1, 2'h0, 14'h0000);
    wr(2'h0, 14'($urandom) & mk[0]);
    u_c.idle(200);
    chk({26'h0, dll_locked_o}, 27'h1);
    wr(2'h1, e1 | 14'h0380);
    wr(2'h1, e1 & ~14'h0380);
    wr(2'h1, e1 | 14'h0800);
    repeat (8) begin
      automatic logic [1:0] b = 2'($urandom);
      wr(b, 14'($urandom) & mk[b]);
    end
    wr(2'h1, e1 & ~14'h0001);
    u_c.k = 1'b0;
    u_c.cmd(3'h1, 2'h0, 14'h0000);
    u_c.cmd(3'h0, 2'h0, 14'h0155);
    chk({25'h0, self_refresh_o, dll_on_o}, 27'h2);
    u_c.k = 1'b1;
    u_c.idle(10);
    chk({25'h0, self_refresh_o, dll_on_o}, 27'h1);
    u_c.idle(250);
    complete_run();
  end
endmodule : test_sdram_init_mode_program
